//--- verilog/fcc_pkg.sv
// package: register map, field layout, timing and types of the flash command controller
package fcc_pkg;
  // register indices (byte address = 4 * index)
  localparam logic [3:0] FCC_IDX_CLKDIV = 4'h0;
  localparam logic [3:0] FCC_IDX_CNFG = 4'h1;
  localparam logic [3:0] FCC_IDX_STAT = 4'h2;
  localparam logic [3:0] FCC_IDX_CCOBIX = 4'h3;
  localparam logic [3:0] FCC_IDX_CCOB = 4'h4;
  localparam logic [3:0] FCC_IDX_PROT = 4'h5;
  localparam logic [3:0] FCC_IDX_OPT = 4'h6;
  localparam logic [3:0] FCC_IDX_SEC = 4'h7;
  localparam logic [3:0] FCC_IDX_STOP = 4'h8;
  localparam int FCC_REG_ADDR_W = 6;
  // status bit positions
  localparam int FCC_ST_COMMAND_COMPLETE_FLAG = 7;
  localparam int FCC_ST_ACCESS_ERROR_FLAG = 5;
  localparam int FCC_ST_MGS_LO = 0;
  // config bit positions
  localparam int FCC_CF_CCIE = 7;
  // clock divider register fields
  localparam int FCC_CD_LOADED = 7;
  // array geometry
  localparam int FCC_ARR_AW = 16;
  localparam int FCC_SECT_AW = 9;
  localparam int FCC_SECTORS = 128;
  localparam logic [23:0] FCC_ARR_TOP_64K = 24'h00_FFFF;
  localparam logic [23:0] FCC_ARR_TOP_128K = 24'h01_FFFF;
  // command codes
  localparam logic [7:0] FCC_CMD_PROG_LW = 8'h06;
  localparam logic [7:0] FCC_CMD_ERASE_SECT = 8'h0A;
  // reset and default values
  localparam logic [7:0] FCC_PROT_DEFAULT = 8'h00;
  localparam logic [7:0] FCC_OPT_DEFAULT = 8'h00;
  localparam logic [7:0] FCC_SEC_DEFAULT = 8'h00;
  localparam logic [7:0] FCC_ERASED_BYTE = 8'hFF;
  localparam logic [2:0] FCC_CCOB_LAST = 3'h5;
  // timing: init and command durations
  localparam int FCC_CLK_MHZ = 100;
  localparam int FCC_INIT_HOLD_NS = 200;
  localparam int FCC_INIT_HOLD_CYC = (FCC_INIT_HOLD_NS * FCC_CLK_MHZ + 999) / 1000;
  localparam int FCC_INIT_TAIL_NS = 100;
  localparam int FCC_INIT_TAIL_CYC = (FCC_INIT_TAIL_NS * FCC_CLK_MHZ + 999) / 1000;
  localparam int FCC_PROG_NS = 400;
  localparam int FCC_PROG_CYC = (FCC_PROG_NS * FCC_CLK_MHZ + 999) / 1000;
  localparam int FCC_ERASE_NS = 5120;
  localparam int FCC_ERASE_CYC = (FCC_ERASE_NS * FCC_CLK_MHZ + 999) / 1000;
  localparam int FCC_CNT_W = 10;

  typedef enum logic [2:0] {
    FCC_INIT_HOLD,
    FCC_INIT_TAIL,
    FCC_IDLE,
    FCC_PROG,
    FCC_ERASE
  } fcc_state_e;

  typedef struct packed {
    logic [FCC_REG_ADDR_W-1:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } fcc_reg_req_s;

  typedef struct packed {
    logic [23:0] addr;
    logic rd;
  } fcc_arr_req_s;
endpackage

//--- verilog/fcc_down_counter.sv
// module: loadable down counter with a done flag
`timescale 1ns/10ps
module fcc_down_counter
  import fcc_pkg::*;
#(
  parameter int W = FCC_CNT_W
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic srst_i,
  // control
  input wire logic load_i,
  input wire logic [W-1:0] value_i,
  // status
  output logic zero_o
);
  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;

  assign cnt_d = load_i ? value_i : ((cnt_q != '0) ? cnt_q - 1'b1 : cnt_q);
  assign zero_o = (cnt_q == '0);

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end
endmodule

//--- verilog/fcc_ctrl.sv
// module: flash command controller with array read port and power-on init
`timescale 1ns/10ps
module fcc_ctrl
  import fcc_pkg::*;
(
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic srst_i,
  // register port
  input wire logic [FCC_REG_ADDR_W-1:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [15:0] reg_rdata_o,
  // array read port
  input wire logic [23:0] arr_addr_i,
  input wire logic arr_rd_i,
  output logic [7:0] arr_rdata_o,
  output logic arr_hit_o,
  output logic stall_o,
  // array size select and init sources: nonvolatile settings and their error flag
  input wire logic big_array_i,
  input wire logic [7:0] nv_prot_i,
  input wire logic [7:0] nv_opt_i,
  input wire logic [7:0] nv_sec_i,
  input wire logic nv_err_i,
  // power management and interrupt
  input wire logic stop_req_i,
  output logic stop_ack_o,
  output logic irq_o
);
  fcc_state_e state_q;
  fcc_state_e state_d;
  fcc_reg_req_s req;
  fcc_arr_req_s areq;
  logic [7:0] mem_q [0:(1<<FCC_ARR_AW)-1];
  logic [15:0] ccob_q [0:FCC_CCOB_LAST];
  logic [2:0] ccobix_q;
  logic [7:0] clkdiv_q;
  logic ccie_q;
  logic command_complete_flag_q;
  logic access_error_flag_q;
  logic [1:0] verify_status_field_q;
  logic [7:0] prot_q;
  logic [7:0] opt_q;
  logic [7:0] sec_q;
  logic [15:0] reg_rdata_q;
  logic [7:0] arr_rdata_q;
  logic arr_hit_q;
  logic stall_q;
  logic stop_ack_q;
  logic irq_q;
  logic [FCC_ARR_AW-1:0] op_addr_q;
  logic [31:0] op_data_q;
  logic [FCC_SECT_AW-1:0] erase_idx_q;

  assign req = '{addr: reg_addr_i, wdata: reg_wdata_i, wr: reg_wr_i, rd: reg_rd_i};
  assign areq = '{addr: arr_addr_i, rd: arr_rd_i};

  // decode
  wire [3:0] idx = req.addr[5:2];
  wire hit_word = (req.addr[1:0] == 2'b00);
  wire wr_stat = req.wr && hit_word && (idx == FCC_IDX_STAT) && !stall_q;
  wire wr_cdiv = req.wr && hit_word && (idx == FCC_IDX_CLKDIV) && !stall_q;
  wire wr_cnfg = req.wr && hit_word && (idx == FCC_IDX_CNFG) && !stall_q;
  wire wr_ix = req.wr && hit_word && (idx == FCC_IDX_CCOBIX) && command_complete_flag_q && !stall_q;
  wire wr_ccob = req.wr && hit_word && (idx == FCC_IDX_CCOB) && command_complete_flag_q && !stall_q;
  wire launch = wr_stat && req.wdata[FCC_ST_COMMAND_COMPLETE_FLAG] && command_complete_flag_q && (state_q == FCC_IDLE);
  wire clr_acc = wr_stat && req.wdata[FCC_ST_ACCESS_ERROR_FLAG];
  wire [7:0] cmd = ccob_q[0][15:8];
  wire [23:0] gaddr = {ccob_q[0][7:0], ccob_q[1]};
  wire div_loaded = clkdiv_q[FCC_CD_LOADED];
  wire is_pe = (cmd == FCC_CMD_PROG_LW) || (cmd == FCC_CMD_ERASE_SECT);
  wire bad_cmd = launch && (!is_pe || !div_loaded);
  wire go_prog = launch && div_loaded && (cmd == FCC_CMD_PROG_LW);
  wire go_erase = launch && div_loaded && (cmd == FCC_CMD_ERASE_SECT);
  wire [23:0] arr_top = big_array_i ? FCC_ARR_TOP_128K : FCC_ARR_TOP_64K;
  // store is 64 KB; the 128 KB decode aliases its upper half onto it
  wire arr_in = (areq.addr <= arr_top);
  wire arr_take = areq.rd && arr_in && !stall_q;
  wire cnt_zero;
  wire cnt_load = (state_q != state_d);
  wire [FCC_CNT_W-1:0] cnt_val = (state_d == FCC_INIT_TAIL) ? FCC_CNT_W'(FCC_INIT_TAIL_CYC) :
                                 (state_d == FCC_PROG) ? FCC_CNT_W'(FCC_PROG_CYC) :
                                 (state_d == FCC_ERASE) ? FCC_CNT_W'(FCC_ERASE_CYC) : '0;
  wire op_done = (state_q == FCC_PROG || state_q == FCC_ERASE) && cnt_zero;
  wire init_done = (state_q == FCC_INIT_TAIL) && cnt_zero;
  wire [15:0] stat_word = {8'h00, command_complete_flag_q, 1'b0, access_error_flag_q, 3'b000, verify_status_field_q};

  // the counter times init tail, program and erase; hold_q times the init hold, starting from reset
  fcc_down_counter #(.W(FCC_CNT_W)) u_cnt (
    .ref_clk_i(ref_clk_i),
    .srst_i(srst_i),
    .load_i(cnt_load),
    .value_i(cnt_val),
    .zero_o(cnt_zero)
  );

  logic [FCC_CNT_W-1:0] hold_q;
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      hold_q <= FCC_CNT_W'(FCC_INIT_HOLD_CYC);
    end else if (hold_q != '0) begin
      hold_q <= hold_q - 1'b1;
    end
  end

  always_comb begin
    state_d = state_q;
    case (state_q)
      FCC_INIT_HOLD: if (hold_q == '0) state_d = FCC_INIT_TAIL;
      FCC_INIT_TAIL: if (cnt_zero) state_d = FCC_IDLE;
      FCC_IDLE: begin
        if (go_prog) state_d = FCC_PROG;
        else if (go_erase) state_d = FCC_ERASE;
      end
      FCC_PROG: if (cnt_zero) state_d = FCC_IDLE;
      FCC_ERASE: if (cnt_zero) state_d = FCC_IDLE;
      default: state_d = FCC_IDLE;
    endcase
  end

  // synchronous reset drops any running command at once
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      state_q <= FCC_INIT_HOLD;
    end else begin
      state_q <= state_d;
    end
  end

  // init loads settings; an error keeps protected/secured defaults
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      prot_q <= FCC_PROT_DEFAULT;
      opt_q <= FCC_OPT_DEFAULT;
      sec_q <= FCC_SEC_DEFAULT;
      verify_status_field_q <= 2'b00;
    end else if (state_q == FCC_INIT_HOLD && hold_q == '0) begin
      if (nv_err_i) begin
        prot_q <= FCC_PROT_DEFAULT;
        opt_q <= FCC_OPT_DEFAULT;
        sec_q <= FCC_SEC_DEFAULT;
        verify_status_field_q <= 2'b11;
      end else begin
        prot_q <= nv_prot_i;
        opt_q <= nv_opt_i;
        sec_q <= nv_sec_i;
      end
    end else if (launch) begin
      verify_status_field_q <= 2'b00;
    end
  end

  // completion flag: low through init and while a command runs
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      command_complete_flag_q <= 1'b0;
    end else if (init_done || op_done) begin
      command_complete_flag_q <= 1'b1;
    end else if (go_prog || go_erase) begin
      command_complete_flag_q <= 1'b0;
    end
  end

  // access error: hardware set wins over software clear
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      access_error_flag_q <= 1'b0;
    end else if (bad_cmd) begin
      access_error_flag_q <= 1'b1;
    end else if (clr_acc) begin
      access_error_flag_q <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      clkdiv_q <= 8'h00;
      ccie_q <= 1'b0;
      ccobix_q <= 3'h0;
    end else begin
      if (wr_cdiv) clkdiv_q <= {1'b1, 1'b0, req.wdata[5:0]};
      if (wr_cnfg) ccie_q <= req.wdata[FCC_CF_CCIE];
      if (wr_ix) ccobix_q <= req.wdata[2:0];
    end
  end

  // command object fields; indices 6 and 7 are unimplemented
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      for (int i = 0; i <= FCC_CCOB_LAST; i++) ccob_q[i] <= 16'h0000;
    end else if (wr_ccob && ccobix_q <= FCC_CCOB_LAST) begin
      ccob_q[ccobix_q] <= req.wdata;
    end
  end

  // command operands captured at launch, then object is locked
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      op_addr_q <= '0;
      op_data_q <= 32'h0000_0000;
      erase_idx_q <= '0;
    end else if (launch) begin
      op_addr_q <= gaddr[FCC_ARR_AW-1:0];
      op_data_q <= {ccob_q[2], ccob_q[3]};
      erase_idx_q <= '0;
    end else if (state_q == FCC_ERASE && erase_idx_q != {FCC_SECT_AW{1'b1}}) begin
      erase_idx_q <= erase_idx_q + 1'b1;
    end
  end

  // array: erase writes ones, program clears bits (and-in)
  wire [FCC_ARR_AW-1:0] erase_a = {op_addr_q[FCC_ARR_AW-1:FCC_SECT_AW], erase_idx_q};
  wire [FCC_ARR_AW-1:0] prog_a = {op_addr_q[FCC_ARR_AW-1:2], 2'b00};
  // model store reads blank after every reset; a real array keeps its contents
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      for (int i = 0; i < (1 << FCC_ARR_AW); i++) mem_q[i] <= FCC_ERASED_BYTE;
    end else if (state_q == FCC_ERASE) begin
      mem_q[erase_a] <= FCC_ERASED_BYTE;
    end else if (op_done && state_q == FCC_PROG) begin
      mem_q[prog_a] <= mem_q[prog_a] & op_data_q[31:24];
      mem_q[prog_a + 16'd1] <= mem_q[prog_a + 16'd1] & op_data_q[23:16];
      mem_q[prog_a + 16'd2] <= mem_q[prog_a + 16'd2] & op_data_q[15:8];
      mem_q[prog_a + 16'd3] <= mem_q[prog_a + 16'd3] & op_data_q[7:0];
    end
  end

  // byte-wide array read, data in the next cycle
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      arr_rdata_q <= 8'h00;
      arr_hit_q <= 1'b0;
    end else begin
      arr_rdata_q <= arr_take ? mem_q[areq.addr[FCC_ARR_AW-1:0]] : 8'h00;
      arr_hit_q <= arr_take;
    end
  end

  // register read
  logic [15:0] rd_mux;
  always_comb begin
    rd_mux = 16'h0000;
    case (idx)
      FCC_IDX_CLKDIV: rd_mux = {8'h00, clkdiv_q};
      FCC_IDX_CNFG: rd_mux = {8'h00, ccie_q, 7'h00};
      FCC_IDX_STAT: rd_mux = stat_word;
      FCC_IDX_CCOBIX: rd_mux = {13'h0000, ccobix_q};
      FCC_IDX_CCOB: rd_mux = (ccobix_q <= FCC_CCOB_LAST) ? ccob_q[ccobix_q] : 16'h0000;
      FCC_IDX_PROT: rd_mux = {8'h00, prot_q};
      FCC_IDX_OPT: rd_mux = {8'h00, opt_q};
      FCC_IDX_SEC: rd_mux = {8'h00, sec_q};
      FCC_IDX_STOP: rd_mux = {15'h0000, stop_ack_q};
      default: rd_mux = 16'h0000;
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      reg_rdata_q <= 16'h0000;
    end else begin
      reg_rdata_q <= (req.rd && hit_word && !stall_q) ? rd_mux : 16'h0000;
    end
  end

  // stall, stop handshake, interrupt
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      stall_q <= 1'b1;
      stop_ack_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      stall_q <= (state_d == FCC_INIT_HOLD);
      stop_ack_q <= stop_req_i && command_complete_flag_q && (state_d == FCC_IDLE) && !launch;
      irq_q <= command_complete_flag_q && ccie_q;
    end
  end

  assign reg_rdata_o = reg_rdata_q;
  assign arr_rdata_o = arr_rdata_q;
  assign arr_hit_o = arr_hit_q;
  assign stall_o = stall_q;
  assign stop_ack_o = stop_ack_q;
  assign irq_o = irq_q;

  // assertions
  property p_lock_ccob;
    @(posedge ref_clk_i) disable iff (srst_i)
      !command_complete_flag_q && (state_q == FCC_PROG) |=> $stable(ccob_q[0]);
  endproperty
  a_lock_ccob: assert property (p_lock_ccob) else $error("command object changed while locked");

  property p_command_complete_flag_init;
    @(posedge ref_clk_i) disable iff (srst_i)
      (state_q == FCC_INIT_HOLD || state_q == FCC_INIT_TAIL) |-> !command_complete_flag_q;
  endproperty
  a_command_complete_flag_init: assert property (p_command_complete_flag_init) else $error("complete flag high during init");

  property p_launch_clears;
    @(posedge ref_clk_i) disable iff (srst_i)
      go_prog |=> !command_complete_flag_q ##[1:45] command_complete_flag_q;
  endproperty
  a_launch_clears: assert property (p_launch_clears) else $error("program did not clear and set flag");

  property p_nodiv_err;
    @(posedge ref_clk_i) disable iff (srst_i)
      launch && !div_loaded |=> access_error_flag_q && command_complete_flag_q;
  endproperty
  a_nodiv_err: assert property (p_nodiv_err) else $error("undivided command ran");

  property p_irq;
    @(posedge ref_clk_i) disable iff (srst_i)
      1'b1 |=> (irq_o == $past(command_complete_flag_q && ccie_q));
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt does not follow flag and enable");

  property p_stop;
    @(posedge ref_clk_i) disable iff (srst_i)
      stop_ack_o |-> $past(command_complete_flag_q);
  endproperty
  a_stop: assert property (p_stop) else $error("stop granted during command");

  property p_stall_read;
    @(posedge ref_clk_i) disable iff (srst_i)
      stall_q |=> !arr_hit_o;
  endproperty
  a_stall_read: assert property (p_stall_read) else $error("array read served during hold");

  property p_init_err;
    @(posedge ref_clk_i) disable iff (srst_i)
      (state_q == FCC_INIT_HOLD) && (hold_q == '0) && nv_err_i |=> verify_status_field_q == 2'b11 && sec_q == FCC_SEC_DEFAULT;
  endproperty
  a_init_err: assert property (p_init_err) else $error("init error not reported");

  c_prog: cover property (@(posedge ref_clk_i) disable iff (srst_i) go_prog ##[1:45] command_complete_flag_q);
  c_erase: cover property (@(posedge ref_clk_i) disable iff (srst_i) go_erase);
  c_stop: cover property (@(posedge ref_clk_i) disable iff (srst_i) stop_req_i && !command_complete_flag_q ##[1:600] stop_ack_o);
endmodule

//--- tb/fcc_host_model.sv
// host-side bus model driving the register and array ports of the controller
`timescale 1ns/10ps
module fcc_host_model
  import fcc_pkg::*;
(
  // clock
  input wire logic ref_clk_i,
  // register port
  output logic [FCC_REG_ADDR_W-1:0] reg_addr_o,
  output logic [15:0] reg_wdata_o,
  output logic reg_wr_o,
  output logic reg_rd_o,
  input wire logic [15:0] reg_rdata_i,
  // array port
  output logic [23:0] arr_addr_o,
  output logic arr_rd_o,
  input wire logic [7:0] arr_rdata_i,
  input wire logic arr_hit_i
);
  initial begin
    reg_addr_o = '0;
    reg_wdata_o = '0;
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
    arr_addr_o = '0;
    arr_rd_o = 1'b0;
  end

  task automatic reg_write(input logic [3:0] idx, input logic [15:0] d);
    @(posedge ref_clk_i);
    reg_addr_o <= {idx, 2'b00};
    reg_wdata_o <= d;
    reg_wr_o <= 1'b1;
    @(posedge ref_clk_i);
    reg_wr_o <= 1'b0;
    // released data must not keep looking valid
    reg_wdata_o <= ~d;
  endtask

  task automatic reg_read(input logic [3:0] idx, output logic [15:0] d);
    @(posedge ref_clk_i);
    reg_addr_o <= {idx, 2'b00};
    reg_rd_o <= 1'b1;
    @(posedge ref_clk_i);
    reg_rd_o <= 1'b0;
    #1 d = reg_rdata_i;
  endtask

  task automatic arr_read(input logic [23:0] a, output logic [15:0] d);
    @(posedge ref_clk_i);
    arr_addr_o <= a;
    arr_rd_o <= 1'b1;
    @(posedge ref_clk_i);
    arr_rd_o <= 1'b0;
    #1 d = {7'h00, arr_hit_i, arr_rdata_i};
  endtask

  // callers only program erased locations, once each
  task automatic run_cmd(input logic [7:0] cmd, input logic [23:0] a, input logic [31:0] data);
    reg_write(FCC_IDX_CCOBIX, 16'h0000);
    reg_write(FCC_IDX_CCOB, {cmd, a[23:16]});
    reg_write(FCC_IDX_CCOBIX, 16'h0001);
    reg_write(FCC_IDX_CCOB, a[15:0]);
    reg_write(FCC_IDX_CCOBIX, 16'h0002);
    reg_write(FCC_IDX_CCOB, data[31:16]);
    reg_write(FCC_IDX_CCOBIX, 16'h0003);
    reg_write(FCC_IDX_CCOB, data[15:0]);
    reg_write(FCC_IDX_STAT, 16'h0080);
  endtask
endmodule

//--- tb/fcc_ctrl_tb.sv
// self-checking bench for the flash command controller
`timescale 1ns/10ps
`define CHK(g, e) chk(16'(g), 16'(e))
module fcc_ctrl_tb;
  import fcc_pkg::*;
  typedef struct packed {logic is_arr; logic [23:0] a; logic [15:0] e;} fcc_row_s;
  logic ref_clk_i, srst_i, reg_wr_i, reg_rd_i, arr_rd_i, arr_hit_o, stall_o;
  logic big_array_i, nv_err_i, stop_req_i, stop_ack_o, irq_o;
  logic [FCC_REG_ADDR_W-1:0] reg_addr_i;
  logic [15:0] reg_wdata_i, reg_rdata_o, d;
  logic [23:0] arr_addr_i;
  logic [7:0] arr_rdata_o, nv_prot_i, nv_opt_i, nv_sec_i;
  int n_fail = 0;
  int checks = 0;
  fcc_row_s rows [8] = '{{1'b0, 20'h0_0000, FCC_IDX_STAT, 16'h0080}, {1'b0, 20'h0_0000, FCC_IDX_CLKDIV, 16'h0000},
    {1'b0, 20'h0_0000, FCC_IDX_PROT, 16'h00A5}, {1'b0, 20'h0_0000, FCC_IDX_OPT, 16'h003C},
    {1'b0, 20'h0_0000, FCC_IDX_SEC, 16'h005A}, {1'b1, 24'h00_0000, 16'h01FF},
    {1'b1, 24'h00_FFFF, 16'h01FF}, {1'b1, 24'h01_0000, 16'h0000}};

  fcc_ctrl uut (.ref_clk_i(ref_clk_i), .srst_i(srst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .arr_addr_i(arr_addr_i),
    .arr_rd_i(arr_rd_i), .arr_rdata_o(arr_rdata_o), .arr_hit_o(arr_hit_o), .stall_o(stall_o),
    .big_array_i(big_array_i), .nv_prot_i(nv_prot_i), .nv_opt_i(nv_opt_i), .nv_sec_i(nv_sec_i),
    .nv_err_i(nv_err_i), .stop_req_i(stop_req_i), .stop_ack_o(stop_ack_o), .irq_o(irq_o));
  fcc_host_model host (.ref_clk_i(ref_clk_i), .reg_addr_o(reg_addr_i), .reg_wdata_o(reg_wdata_i),
    .reg_wr_o(reg_wr_i), .reg_rd_o(reg_rd_i), .reg_rdata_i(reg_rdata_o), .arr_addr_o(arr_addr_i),
    .arr_rd_o(arr_rd_i), .arr_rdata_i(arr_rdata_o), .arr_hit_i(arr_hit_o));

  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // bounded poll: erase is the longest wait, well under 600 reads
  task automatic wait_command_complete_flag();
    logic [15:0] s;
    s = '0;
    for (int i = 0; i < 600 && s[FCC_ST_COMMAND_COMPLETE_FLAG] !== 1'b1; i++) host.reg_read(FCC_IDX_STAT, s);
    `CHK(s[FCC_ST_COMMAND_COMPLETE_FLAG], 1'b1);
  endtask

  task automatic wait_ready();
    logic [15:0] s;
    for (int i = 0; i < 100 && stall_o !== 1'b0; i++) @(posedge ref_clk_i);
    `CHK(stall_o, 1'b0);
    host.reg_read(FCC_IDX_STAT, s);
    `CHK(s[FCC_ST_COMMAND_COMPLETE_FLAG], 1'b0);
    host.arr_read(24'h00_0000, s);
    `CHK(s, 16'h01FF);
    wait_command_complete_flag();
  endtask

  initial begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end

  initial begin
    repeat (20000) @(posedge ref_clk_i);
    n_fail++;
    stop_test();
  end

  initial begin
    srst_i = 1'b1;
    big_array_i = 1'b0;
    nv_prot_i = 8'hA5;
    nv_opt_i = 8'h3C;
    nv_sec_i = 8'h5A;
    nv_err_i = 1'b0;
    stop_req_i = 1'b0;
    repeat (16) @(posedge ref_clk_i);
    `CHK(stall_o, 1'b1);
    srst_i <= 1'b0;
    host.arr_read(24'h00_0000, d);
    `CHK(d, 16'h0000);
    wait_ready();
    foreach (rows[i]) begin
      if (rows[i].is_arr) host.arr_read(rows[i].a, d);
      else host.reg_read(rows[i].a[3:0], d);
      `CHK(d, rows[i].e);
    end
    // large-array decode: top of 128 KB is served, one past it is not
    big_array_i <= 1'b1;
    host.arr_read(24'h01_FFFF, d);
    `CHK(d, 16'h01FF);
    host.arr_read(24'h02_0000, d);
    `CHK(d, 16'h0000);
    big_array_i <= 1'b0;
    // no divider write yet: command refused with access error
    host.run_cmd(FCC_CMD_PROG_LW, 24'h00_0100, 32'h1234_5678);
    host.reg_read(FCC_IDX_STAT, d);
    `CHK(d, 16'h00A0);
    host.arr_read(24'h00_0100, d);
    `CHK(d, 16'h01FF);
    host.reg_write(FCC_IDX_STAT, 16'h0020);
    host.reg_write(FCC_IDX_CLKDIV, 16'h0005);
    host.reg_read(FCC_IDX_CLKDIV, d);
    `CHK(d, 16'h0085);
    host.reg_write(FCC_IDX_CNFG, 16'h0080);
    stop_req_i <= 1'b1;
    host.run_cmd(FCC_CMD_PROG_LW, 24'h00_0100, 32'h1234_5678);
    host.reg_read(FCC_IDX_STAT, d);
    `CHK(d, 16'h0000);
    `CHK(irq_o, 1'b0);
    `CHK(stop_ack_o, 1'b0);
    host.reg_write(FCC_IDX_CCOBIX, 16'h0000);
    host.reg_read(FCC_IDX_CCOBIX, d);
    `CHK(d, 16'h0003);
    host.reg_write(FCC_IDX_STAT, 16'h0080);
    repeat (20) @(posedge ref_clk_i);
    host.reg_read(FCC_IDX_STAT, d);
    `CHK(d[FCC_ST_COMMAND_COMPLETE_FLAG], 1'b0);
    `CHK(stop_ack_o, 1'b0);
    wait_command_complete_flag();
    `CHK(irq_o, 1'b1);
    `CHK(stop_ack_o, 1'b1);
    stop_req_i <= 1'b0;
    for (int k = 0; k < 4; k++) begin
      host.arr_read(24'h00_0100 + 24'(k), d);
      `CHK(d, {8'h01, 8'(32'h1234_5678 >> (24 - 8 * k))});
    end
    host.run_cmd(FCC_CMD_ERASE_SECT, 24'h00_0100, 32'h0000_0000);
    wait_command_complete_flag();
    host.arr_read(24'h00_0103, d);
    `CHK(d, 16'h01FF);
    host.reg_write(FCC_IDX_CNFG, 16'h0000);
    repeat (2) @(posedge ref_clk_i);
    `CHK(irq_o, 1'b0);
    // reset in mid-command with a failing init
    host.run_cmd(FCC_CMD_PROG_LW, 24'h00_0104, 32'h0000_0000);
    repeat (3) @(posedge ref_clk_i);
    srst_i <= 1'b1;
    nv_err_i <= 1'b1;
    repeat (2) @(posedge ref_clk_i);
    srst_i <= 1'b0;
    wait_ready();
    host.arr_read(24'h00_0104, d);
    `CHK(d, 16'h01FF);
    for (int i = 0; i < 5; i++) begin
      host.reg_read(rows[i].a[3:0], d);
      `CHK(d, (i == 0) ? 16'h0083 : 16'h0000);
    end
    stop_test();
  end
endmodule
